// ==== bench/fpbs_checker.sv ====
`timescale 1ns/1ns
`include "fpbs_defines.vh"
// ==========================================
// port-level checks of the sequencer
module fpbs_checker (
  // clock and reset
  input wire        CLK,
  input wire        RESET_N,
  // apb
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [7:0]  PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  // pins
  input wire        DRIVE_FAULT,
  input wire        DRIVE_START,
  input wire        PERMIT_PRESS,
  input wire        PART_LOAD,
  input wire        NV_WE
);
  // shadow of the auto bit, so permit can be tied to the mode
  reg auto_q;
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N)
      auto_q <= 1'b0;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == `FPBS_A_CTRL)
      auto_q <= PWDATA[`FPBS_CT_AUTO];
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_access; PSEL && PENABLE; endsequence
  property p_ready_wait; s_setup |=> PREADY; endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("pready late after setup");
  property p_ready_one; PREADY |-> s_access ##1 !PREADY; endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("pready outside one access cycle");
  property p_err_zero; PSLVERR && !PWRITE |-> PREADY && PRDATA == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("refused read not zero");
  property p_permit_auto; !auto_q [*2] |-> !PERMIT_PRESS; endproperty
  a_permit_auto: assert property (p_permit_auto)
    else $error("permit high in manual");
  property p_permit_fault; DRIVE_FAULT [*5] |-> !PERMIT_PRESS; endproperty
  a_permit_fault: assert property (p_permit_fault)
    else $error("permit high during fault");
  property p_fault_abort; DRIVE_FAULT [*5] |-> !DRIVE_START; endproperty
  a_fault_abort: assert property (p_fault_abort)
    else $error("feed not halted by fault");
  property p_part_pulse; PART_LOAD |=> !PART_LOAD; endproperty
  a_part_pulse: assert property (p_part_pulse)
    else $error("part load longer than one cycle");
  property p_nv_pulse; NV_WE |=> !NV_WE; endproperty
  a_nv_pulse: assert property (p_nv_pulse)
    else $error("totals store strobe too long");
endmodule
bind fpbs_top fpbs_checker u_fpbs_checker (.CLK(CLK), .RESET_N(RESET_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .DRIVE_FAULT(DRIVE_FAULT), .DRIVE_START(DRIVE_START),
  .PERMIT_PRESS(PERMIT_PRESS), .PART_LOAD(PART_LOAD), .NV_WE(NV_WE));

// ==== bench/fpbs_drive_model.sv ====
`timescale 1ns/1ns
// ==========================================
// servo drive: moves while commanded, reports arrival
module fpbs_drive_model (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // command
  input  wire drive_start,
  input  wire slow,
  // status back
  output reg  axis_moving,
  output reg  in_position
);
  reg [4:0] cnt_q;
  reg       done_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q       <= 5'h00;
      done_q      <= 1'b0;
      axis_moving <= 1'b0;
      in_position <= 1'b1;
    end else if (!drive_start) begin
      // an aborted move stops short, so arrival stays low
      cnt_q       <= 5'h00;
      done_q      <= 1'b0;
      axis_moving <= 1'b0;
    end else if (cnt_q == 5'h00 && !done_q) begin
      cnt_q       <= slow ? 5'h14 : 5'h05;
      in_position <= 1'b0;
    end else if (cnt_q != 5'h00) begin
      cnt_q       <= cnt_q - 5'h01;
      axis_moving <= (cnt_q != 5'h01);
      in_position <= (cnt_q == 5'h01);
      done_q      <= (cnt_q == 5'h01);
    end
  end
endmodule

// ==== bench/fpbs_top_tb.sv ====
`timescale 1ns/1ns
`include "fpbs_defines.vh"
module fpbs_top_tb;
  // ==========================================
  // signals
  reg         CLK = 1'b0;
  reg         RESET_N = 1'b0;
  reg         PSEL = 1'b0;
  reg         PENABLE = 1'b0;
  reg         PWRITE = 1'b0;
  reg  [7:0]  PADDR = 8'h00;
  reg  [31:0] PWDATA = 32'h0;
  reg         FEED_ANGLE = 1'b0;
  reg         PARAM_REQ = 1'b1;
  reg         DRIVE_FAULT = 1'b0;
  reg         slow = 1'b0;
  wire [31:0] PRDATA, PART_LEN, NV_LEN, NV_PCS;
  wire        PREADY, PSLVERR, AXIS_MOVING, IN_POSITION, DRIVE_START;
  wire        PERMIT_PRESS, STOP_LAMP, PART_LOAD, NV_WE;
  wire [6:0]  PART_NUM;
  reg  [31:0] rd_q;
  reg         er_q;
  integer     failures = 0;
  integer     checked = 0;
  always #2 CLK = ~CLK;
  // ==========================================
  // design and drive
  fpbs_top #(.FLASH_HALF_CYC(32'h8)) u_fpbs_top (.CLK(CLK),
    .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FEED_ANGLE(FEED_ANGLE), .PARAM_REQ(PARAM_REQ),
    .AXIS_MOVING(AXIS_MOVING), .IN_POSITION(IN_POSITION),
    .DRIVE_FAULT(DRIVE_FAULT), .DRIVE_START(DRIVE_START),
    .PERMIT_PRESS(PERMIT_PRESS), .STOP_LAMP(STOP_LAMP),
    .PART_LOAD(PART_LOAD), .PART_NUM(PART_NUM), .PART_LEN(PART_LEN),
    .NV_LEN_IN(32'h10), .NV_PCS_IN(32'h3), .NV_WE(NV_WE),
    .NV_LEN(NV_LEN), .NV_PCS(NV_PCS));
  fpbs_drive_model u_fpbs_drive_model (.clk(CLK), .rst_n(RESET_N),
    .drive_start(DRIVE_START), .slow(slow), .axis_moving(AXIS_MOVING),
    .in_position(IN_POSITION));
  // ==========================================
  // tasks
  task final_report;
    begin
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("BAD %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task apb(input [7:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge CLK);
      PSEL    <= 1'b1;
      PWRITE  <= w;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      @(posedge CLK);
      while (PREADY !== 1'b1 && n < 16) begin
        n = n + 1;
        @(posedge CLK);
      end
      if (n == 16) begin
        failures = failures + 1;
        final_report;
      end
      rd_q = PRDATA;
      er_q = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp, input [63:0] nm);
    begin
      apb(a, 1'b0, 32'h0);
      chk(nm, exp, rd_q);
    end
  endtask
  task cmd(input integer b);
    apb(`FPBS_A_CMD, 1'b1, 32'h1 << b);
  endtask
  task pm(input v);
    chk("permit", {31'h0, v}, {31'h0, PERMIT_PRESS});
  endtask
  // bounded wait on drive start (0) or part load (1)
  task wt(input integer s, input v);
    integer n;
    begin
      n = 0;
      while ((s ? PART_LOAD : DRIVE_START) !== v && n < 200) begin
        n = n + 1;
        @(posedge CLK);
      end
      if (n == 200) begin
        failures = failures + 1;
        final_report;
      end
    end
  endtask
  task settle;
    repeat (4) @(posedge CLK);
  endtask
  // lamp high cycles over a window of 32, one edge after the call
  task lamp(input [31:0] exp);
    integer i, h;
    begin
      h = 0;
      @(posedge CLK);
      for (i = 0; i < 32; i = i + 1) begin
        @(posedge CLK);
        h = h + STOP_LAMP;
      end
      chk("lamp", exp, h);
    end
  endtask
  task stroke;
    begin
      FEED_ANGLE <= 1'b1;
      wt(0, 1'b1);
      wt(0, 1'b0);
      settle;
      FEED_ANGLE <= 1'b0;
      settle;
      settle;
    end
  endtask
  // ==========================================
  // sequence
  initial begin
    #200000;
    failures = failures + 1;
    final_report;
  end
  initial begin
    repeat (5) @(posedge CLK);
    RESET_N <= 1'b1;
    rdc(`FPBS_A_CTRL, 32'h0, "ctrl");
    rdc(`FPBS_A_TOTLEN, 32'h10, "totlen");
    rdc(`FPBS_A_TOTPCS, 32'h3, "totpcs");
    rdc(8'h28, 32'h0, "unmapped");
    chk("err", 32'h1, {31'h0, er_q});
    apb(`FPBS_A_STATUS, 1'b0, 32'h0);
    chk("inputs", 32'ha, {28'h0, rd_q[3:0]});
    PARAM_REQ <= 1'b0;
    apb(`FPBS_A_PARTNUM, 1'b1, 32'h5);
    apb(`FPBS_A_PARTLEN, 1'b1, 32'h64);
    cmd(`FPBS_C_PART);
    wt(1, 1'b1);
    chk("partnum", 32'h5, {25'h0, PART_NUM});
    chk("partlen", 32'h64, PART_LEN);
    cmd(`FPBS_C_INC);
    rdc(`FPBS_A_COUNT, 32'h0, "count");
    apb(`FPBS_A_QTY, 1'b1, 32'h5);
    cmd(`FPBS_C_INC);
    cmd(`FPBS_C_INC);
    cmd(`FPBS_C_DEC);
    rdc(`FPBS_A_COUNT, 32'h1, "count");
    cmd(`FPBS_C_CCLR);
    rdc(`FPBS_A_COUNT, 32'h0, "count");
    apb(`FPBS_A_CTRL, 1'b1, 32'h7);
    apb(`FPBS_A_QTY, 1'b1, 32'h3);
    cmd(`FPBS_C_START);
    stroke;
    rdc(`FPBS_A_COUNT, 32'h1, "count");
    pm(1'b1);
    apb(`FPBS_A_QTY, 1'b1, 32'h2);
    stroke;
    rdc(`FPBS_A_COUNT, 32'h0, "count");
    pm(1'b0);
    rdc(`FPBS_A_TOTPCS, 32'h5, "totpcs");
    rdc(`FPBS_A_TOTLEN, 32'hd8, "totlen");
    chk("nvlen", 32'hd8, NV_LEN);
    FEED_ANGLE <= 1'b1;
    repeat (20) @(posedge CLK);
    chk("start", 32'h0, {31'h0, DRIVE_START});
    FEED_ANGLE <= 1'b0;
    apb(`FPBS_A_CTRL, 1'b1, 32'h3);
    apb(`FPBS_A_QTY, 1'b1, 32'h1);
    cmd(`FPBS_C_START);
    stroke;
    apb(`FPBS_A_STATUS, 1'b0, 32'h0);
    chk("flash", 32'h1, {31'h0, rd_q[10]});
    lamp(32'h10);
    slow <= 1'b1;
    FEED_ANGLE <= 1'b1;
    wt(0, 1'b1);
    cmd(`FPBS_C_STOP);
    wt(0, 1'b0);
    settle;
    rdc(`FPBS_A_COUNT, 32'h2, "count");
    pm(1'b0);
    FEED_ANGLE <= 1'b0;
    cmd(`FPBS_C_CCLR);
    lamp(32'h0);
    cmd(`FPBS_C_START);
    FEED_ANGLE <= 1'b1;
    wt(0, 1'b1);
    cmd(`FPBS_C_ISTOP);
    wt(0, 1'b0);
    settle;
    rdc(`FPBS_A_TOTPCS, 32'h7, "totpcs");
    rdc(`FPBS_A_COUNT, 32'h0, "count");
    FEED_ANGLE <= 1'b0;
    slow <= 1'b0;
    cmd(`FPBS_C_CLEN);
    rdc(`FPBS_A_TOTLEN, 32'h0, "totlen");
    rdc(`FPBS_A_TOTPCS, 32'h7, "totpcs");
    cmd(`FPBS_C_CPCS);
    rdc(`FPBS_A_TOTPCS, 32'h0, "totpcs");
    apb(`FPBS_A_CTRL, 1'b1, 32'hb);
    apb(`FPBS_A_STATUS, 1'b0, 32'h0);
    chk("mode", 32'h0, {31'h0, rd_q[8]});
    cmd(`FPBS_C_CONF);
    apb(`FPBS_A_STATUS, 1'b0, 32'h0);
    chk("mode", 32'h1, {31'h0, rd_q[8]});
    cmd(`FPBS_C_START);
    stroke;
    pm(1'b1);
    FEED_ANGLE <= 1'b1;
    wt(0, 1'b1);
    repeat (2) @(posedge CLK);
    pm(1'b0);
    wt(0, 1'b0);
    settle;
    FEED_ANGLE <= 1'b0;
    cmd(`FPBS_C_STOP);
    settle;
    pm(1'b0);
    apb(`FPBS_A_CTRL, 1'b1, 32'h1);
    cmd(`FPBS_C_CONF);
    cmd(`FPBS_C_START);
    settle;
    pm(1'b1);
    DRIVE_FAULT <= 1'b1;
    repeat (6) @(posedge CLK);
    pm(1'b0);
    DRIVE_FAULT <= 1'b0;
    apb(`FPBS_A_CTRL, 1'b1, 32'h9);
    cmd(`FPBS_C_CONF);
    cmd(`FPBS_C_START);
    settle;
    pm(1'b1);
    FEED_ANGLE <= 1'b1;
    wt(0, 1'b1);
    repeat (2) @(posedge CLK);
    pm(1'b0);
    wt(0, 1'b0);
    settle;
    pm(1'b1);
    FEED_ANGLE <= 1'b0;
    apb(`FPBS_A_CTRL, 1'b1, 32'h0);
    settle;
    pm(1'b0);
    // two falling angle edges forty microseconds apart, no feed between
    FEED_ANGLE <= 1'b1;
    settle;
    FEED_ANGLE <= 1'b0;
    repeat (`FPBS_TICK_CYC * 32'h28 - 32'h4) @(posedge CLK);
    FEED_ANGLE <= 1'b1;
    settle;
    FEED_ANGLE <= 1'b0;
    repeat (100) @(posedge CLK);
    rdc(`FPBS_A_RATE, (`FPBS_US_PER_MIN / 32'h28) & 32'hffff,
        "rate");
    final_report;
  end
endmodule

// ==== core/fpbs_rate_meter.v ====
`timescale 1ns/1ns
`include "fpbs_defines.vh"
// ==========================================
// stroke period and feed duty, timed in microseconds
module fpbs_rate_meter (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // levels on clk
  input  wire        feed_angle,
  input  wire        feed_active,
  // results
  output reg  [31:0] rate_q,
  output reg  [31:0] use_q
);
  localparam [31:0] TICK_LAST = `FPBS_TICK_CYC - 1;
  reg  [31:0] tick_q;
  reg  [31:0] per_q;
  reg  [31:0] act_q;
  reg  [31:0] den_q;
  reg  [31:0] act_hold_q;
  reg  [31:0] n_q;
  reg  [32:0] r_q;
  reg  [5:0]  i_q;
  reg         busy_q;
  reg         ph_q;
  reg         fa_p_q;
  wire        tick = (tick_q == TICK_LAST);
  wire        fall = fa_p_q & ~feed_angle;
  wire [32:0] r_sh = {r_q[31:0], n_q[31]};
  wire        ge   = (r_sh >= {1'b0, den_q});
  wire [63:0] pct  = act_hold_q * `FPBS_PERCENT;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 32'h0; per_q <= 32'h0; act_q <= 32'h0;
      den_q <= 32'h0; act_hold_q <= 32'h0; n_q <= 32'h0;
      r_q <= 33'h0; i_q <= 6'h0; busy_q <= 1'b0; ph_q <= 1'b0;
      fa_p_q <= 1'b0; rate_q <= 32'h0; use_q <= 32'h0;
    end else begin
      fa_p_q <= feed_angle;
      tick_q <= tick ? 32'h0 : tick_q + 32'h1;
      // period runs falling edge to falling edge
      if (fall) begin
        // the tick of the edge cycle opens the new period, so none is lost
        per_q <= {31'h0, tick};
        act_q <= {31'h0, tick & feed_active};
        if (!busy_q && per_q != 32'h0) begin
          den_q      <= per_q;
          act_hold_q <= act_q;
          n_q        <= `FPBS_US_PER_MIN;
          r_q        <= 33'h0;
          i_q        <= 6'h0;
          ph_q       <= 1'b0;
          busy_q     <= 1'b1;
        end
      end else if (tick) begin
        per_q <= per_q + 32'h1;
        if (feed_active)
          act_q <= act_q + 32'h1;
      end
      // one shared serial divider: rate first, then duty
      if (busy_q) begin
        r_q <= ge ? r_sh - {1'b0, den_q} : r_sh;
        n_q <= {n_q[30:0], ge};
        i_q <= i_q + 6'h1;
        if (i_q == 6'h1f) begin
          if (!ph_q) begin
            rate_q <= {n_q[30:0], ge};
            n_q    <= pct[31:0];
            r_q    <= 33'h0;
            i_q    <= 6'h0;
            ph_q   <= 1'b1;
          end else begin
            use_q  <= {n_q[30:0], ge};
            busy_q <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// ==== core/fpbs_sync.v ====
`timescale 1ns/1ns
// ==========================================
// two-flop synchroniser for pin inputs
module fpbs_sync #(
  parameter W = 5
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // pins and synced levels
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// ==== core/fpbs_top.v ====
`timescale 1ns/1ns
`include "fpbs_defines.vh"
module fpbs_top #(
  parameter [31:0] FLASH_HALF_CYC = `FPBS_FLASH_CYC
) (
  // clock and reset
  input  wire        CLK,
  input  wire        RESET_N,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // discrete pins
  input  wire        FEED_ANGLE,
  input  wire        PARAM_REQ,
  input  wire        AXIS_MOVING,
  input  wire        IN_POSITION,
  input  wire        DRIVE_FAULT,
  // drive and press
  output reg         DRIVE_START,
  output reg         PERMIT_PRESS,
  output reg         STOP_LAMP,
  output reg         PART_LOAD,
  output reg  [6:0]  PART_NUM,
  output reg  [31:0] PART_LEN,
  // nonvolatile totals store
  input  wire [31:0] NV_LEN_IN,
  input  wire [31:0] NV_PCS_IN,
  output reg         NV_WE,
  output reg  [31:0] NV_LEN,
  output reg  [31:0] NV_PCS
);
  // ==========================================
  // sequencer states
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_ARM   = 3'h1;
  localparam [2:0] S_FEED  = 3'h2;
  localparam [2:0] S_MOVE  = 3'h3;
  localparam [2:0] S_REARM = 3'h4;
  localparam [`FPBS_QTY_W-1:0] Q_ZERO = {`FPBS_QTY_W{1'b0}};
  localparam [`FPBS_QTY_W-1:0] Q_ONE  = {{(`FPBS_QTY_W-1){1'b0}}, 1'b1};

  // ==========================================
  // input synchronisation
  wire [4:0] pins_s;
  fpbs_sync #(
    .W (5)
  ) u_sync (
    .clk   (CLK),
    .rst_n (RESET_N),
    .din   ({DRIVE_FAULT, IN_POSITION, AXIS_MOVING, PARAM_REQ, FEED_ANGLE}),
    .dout  (pins_s)
  );
  wire fa_s  = pins_s[0];
  wire mov_s = pins_s[2];
  wire pos_s = pins_s[3];
  wire flt_s = pins_s[4];

  // ==========================================
  // state
  reg [`FPBS_CT_W-1:0]   ctrl_q;
  reg [`FPBS_QTY_W-1:0]  qty_q;
  reg [`FPBS_QTY_W-1:0]  count_q;
  reg [`FPBS_QTY_W-1:0]  count_d;
  reg [`FPBS_PART_W-1:0] pnum_q;
  reg [31:0]             plen_q;
  reg [31:0]             cyc_len_q;
  reg [2:0]              state_q;
  reg [2:0]              state_d;
  reg                    int_q;
  reg                    stop_req_q;
  reg                    fa_p_q;
  reg                    flash_q;
  reg                    ph_q;
  reg [31:0]             flash_cnt_q;
  reg                    nv_load_q;
  reg                    permit_d;
  reg [31:0]             rdata_d;
  reg                    err_d;
  wire [31:0]            rate_w;
  wire [31:0]            use_w;

  // ==========================================
  // apb decode; no wait states, writes act in the access phase
  wire apb_acc = PSEL & PENABLE & PREADY;
  wire apb_wr  = apb_acc & PWRITE;
  wire wr_cmd  = apb_wr & (PADDR == `FPBS_A_CMD);
  wire c_start = wr_cmd & PWDATA[`FPBS_C_START];
  wire c_stop  = wr_cmd & PWDATA[`FPBS_C_STOP];
  wire c_istop = wr_cmd & PWDATA[`FPBS_C_ISTOP];
  wire c_inc   = wr_cmd & PWDATA[`FPBS_C_INC];
  wire c_dec   = wr_cmd & PWDATA[`FPBS_C_DEC];
  wire c_cclr  = wr_cmd & PWDATA[`FPBS_C_CCLR];
  wire c_clen  = wr_cmd & PWDATA[`FPBS_C_CLEN];
  wire c_cpcs  = wr_cmd & PWDATA[`FPBS_C_CPCS];
  wire c_conf  = wr_cmd & PWDATA[`FPBS_C_CONF];
  wire c_part  = wr_cmd & PWDATA[`FPBS_C_PART];

  // ==========================================
  // sequencing terms
  wire auto    = ctrl_q[`FPBS_CT_AUTO];
  wire fbp     = ctrl_q[`FPBS_CT_FBP];
  wire bstop   = ctrl_q[`FPBS_CT_BSTOP];
  wire fa_rise = fa_s & ~fa_p_q;
  // leaving auto, a fault or an immediate stop cuts the feed; no totals
  wire abort   = ~auto | flt_s | c_istop;
  wire done    = (state_q == S_MOVE) & ~mov_s & pos_s;
  wire free    = (qty_q == Q_ZERO);
  wire [`FPBS_QTY_W-1:0] cnt_inc = count_q + Q_ONE;
  // compare against the live quantity at the completion edge
  wire reached = ~free & (cnt_inc >= qty_q);
  wire go      = (state_q == S_IDLE) & auto & c_start & ~flt_s;
  wire halt    = stop_req_q | c_stop;

  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE:  if (go) state_d = S_ARM;
      // press-first needs a fresh rising edge, feed-first just a high level
      S_ARM:   if (halt) state_d = S_IDLE;
               else if (fbp ? fa_s : fa_rise) state_d = S_FEED;
      S_FEED:  if (mov_s) state_d = S_MOVE;
      S_MOVE:  if (done) begin
                 if (halt || (reached && bstop))
                   state_d = S_IDLE;
                 else
                   state_d = S_REARM;
               end
      // rearm waits for the angle to fall so one stroke feeds once
      S_REARM: if (halt) state_d = S_IDLE;
               else if (!fa_s) state_d = S_ARM;
      default: state_d = S_IDLE;
    endcase
    if (abort)
      state_d = S_IDLE;
  end

  // ==========================================
  // press permit
  always @* begin
    permit_d = PERMIT_PRESS;
    if (!auto || state_d == S_IDLE)
      permit_d = 1'b0;
    else if (flt_s || halt)
      permit_d = 1'b0;
    // the angle edge wins over a completion seen in the same cycle
    else if (int_q && fa_rise)
      permit_d = 1'b0;
    else if (done && (fbp || int_q))
      permit_d = 1'b1;
    else if (go && !fbp)
      permit_d = 1'b1;
  end

  // ==========================================
  // piece count; a clear applies first, and a completion in the same cycle still counts
  always @* begin
    count_d = count_q;
    if (c_cclr)
      count_d = Q_ZERO;
    else if (c_inc && !free)
      count_d = cnt_inc;
    else if (c_dec && !free && count_q != Q_ZERO)
      count_d = count_q - Q_ONE;
    if (done) begin
      if (reached && bstop)
        count_d = Q_ZERO;
      else
        count_d = count_d + Q_ONE;
    end
  end

  // ==========================================
  // sequencer, counters and outputs
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_q       <= `FPBS_CT_RST;
      qty_q        <= Q_ZERO;
      count_q      <= Q_ZERO;
      pnum_q       <= 7'h00;
      plen_q       <= 32'h0;
      cyc_len_q    <= 32'h0;
      state_q      <= S_IDLE;
      int_q        <= 1'b0;
      stop_req_q   <= 1'b0;
      fa_p_q       <= 1'b0;
      flash_q      <= 1'b0;
      ph_q         <= 1'b0;
      flash_cnt_q  <= 32'h0;
      nv_load_q    <= 1'b1;
      DRIVE_START  <= 1'b0;
      PERMIT_PRESS <= 1'b0;
      STOP_LAMP    <= 1'b0;
      PART_LOAD    <= 1'b0;
      PART_NUM     <= 7'h00;
      PART_LEN     <= 32'h0;
      NV_WE        <= 1'b0;
      NV_LEN       <= 32'h0;
      NV_PCS       <= 32'h0;
    end else begin
      fa_p_q       <= fa_s;
      state_q      <= state_d;
      count_q      <= count_d;
      PERMIT_PRESS <= permit_d;
      DRIVE_START  <= (state_d == S_FEED) || (state_d == S_MOVE);
      if (apb_wr && PADDR == `FPBS_A_CTRL)
        ctrl_q <= PWDATA[`FPBS_CT_W-1:0];
      if (apb_wr && PADDR == `FPBS_A_QTY)
        qty_q <= PWDATA[`FPBS_QTY_W-1:0];
      if (apb_wr && PADDR == `FPBS_A_PARTNUM)
        pnum_q <= PWDATA[`FPBS_PART_W-1:0];
      if (apb_wr && PADDR == `FPBS_A_PARTLEN)
        plen_q <= PWDATA;
      // the pending mode bit is inert until confirmed
      if (c_conf)
        int_q <= ctrl_q[`FPBS_CT_INT];
      // part data goes out now; the running feed keeps its own length
      PART_LOAD <= c_part;
      if (c_part) begin
        PART_NUM <= pnum_q;
        PART_LEN <= plen_q;
      end
      if (state_q == S_ARM && state_d == S_FEED)
        cyc_len_q <= PART_LEN;
      if (state_d == S_IDLE)
        stop_req_q <= 1'b0;
      else if (c_stop)
        stop_req_q <= 1'b1;
      // batch-complete indicator
      if (done && reached && !bstop)
        flash_q <= 1'b1;
      else if (c_cclr || go)
        flash_q <= 1'b0;
      if (flash_cnt_q >= FLASH_HALF_CYC - 32'h1) begin
        flash_cnt_q <= 32'h0;
        ph_q        <= ~ph_q;
      end else begin
        flash_cnt_q <= flash_cnt_q + 32'h1;
      end
      STOP_LAMP <= flash_q & ph_q;
      // totals: restored from the store after reset, then kept there
      // a clear meeting a completion keeps only the new feed's amount
      NV_WE <= done | c_clen | c_cpcs;
      if (nv_load_q) begin
        nv_load_q <= 1'b0;
        NV_LEN    <= NV_LEN_IN;
        NV_PCS    <= NV_PCS_IN;
      end else begin
        NV_LEN <= (c_clen ? 32'h0 : NV_LEN)
                  + (done ? cyc_len_q : 32'h0);
        NV_PCS <= (c_cpcs ? 32'h0 : NV_PCS)
                  + (done ? 32'h1 : 32'h0);
      end
    end
  end

  // ==========================================
  // stroke rate and feed usage
  // usage counts commanded feed time, which leads real axis motion
  fpbs_rate_meter u_rate (
    .clk         (CLK),
    .rst_n       (RESET_N),
    .feed_angle  (fa_s),
    .feed_active (DRIVE_START),
    .rate_q      (rate_w),
    .use_q       (use_w)
  );

  // ==========================================
  // read mux
  always @* begin
    rdata_d = 32'h0;
    err_d   = 1'b0;
    case (PADDR)
      `FPBS_A_CTRL:    rdata_d[`FPBS_CT_W-1:0] = ctrl_q;
      `FPBS_A_CMD:     rdata_d = 32'h0;
      `FPBS_A_QTY:     rdata_d[`FPBS_QTY_W-1:0] = qty_q;
      `FPBS_A_COUNT:   rdata_d[`FPBS_QTY_W-1:0] = count_q;
      `FPBS_A_PARTNUM: rdata_d[`FPBS_PART_W-1:0] = pnum_q;
      `FPBS_A_PARTLEN: rdata_d = plen_q;
      `FPBS_A_STATUS: begin
        rdata_d[`FPBS_ST_PINS_W-1:0] = pins_s;
        rdata_d[`FPBS_ST_STATE+:3]   = state_q;
        rdata_d[`FPBS_ST_INT]        = int_q;
        rdata_d[`FPBS_ST_PERMIT]     = PERMIT_PRESS;
        rdata_d[`FPBS_ST_FLASH]      = flash_q;
      end
      `FPBS_A_TOTLEN:  rdata_d = NV_LEN;
      `FPBS_A_TOTPCS:  rdata_d = NV_PCS;
      // a rate beyond sixteen bits wraps; only the low bits are shown
      `FPBS_A_RATE: begin
        rdata_d[`FPBS_RT_W-1:0] = rate_w[`FPBS_RT_W-1:0];
        rdata_d[`FPBS_USE_LSB+:`FPBS_USE_W] =
          use_w[`FPBS_USE_W-1:0];
      end
      default:         err_d = 1'b1;
    endcase
  end

  // read data is taken at setup so it stands through the access cycle
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & err_d;
      if (PSEL && !PENABLE && !PWRITE)
        PRDATA <= rdata_d;
    end
  end
endmodule

// ==== inc/fpbs_defines.vh ====
`ifndef FPBS_DEFINES_VH
`define FPBS_DEFINES_VH
// ==========================================
// register byte offsets
`define FPBS_A_CTRL     8'h00
`define FPBS_A_CMD      8'h04
`define FPBS_A_QTY      8'h08
`define FPBS_A_COUNT    8'h0c
`define FPBS_A_PARTNUM  8'h10
`define FPBS_A_PARTLEN  8'h14
`define FPBS_A_STATUS   8'h18
`define FPBS_A_TOTLEN   8'h1c
`define FPBS_A_TOTPCS   8'h20
`define FPBS_A_RATE     8'h24
// ==========================================
// control register fields
`define FPBS_CT_W       4
`define FPBS_CT_AUTO    0
`define FPBS_CT_FBP     1
`define FPBS_CT_BSTOP   2
`define FPBS_CT_INT     3
`define FPBS_CT_RST     4'h0
// ==========================================
// command register bits, write one to act
`define FPBS_C_START    0
`define FPBS_C_STOP     1
`define FPBS_C_ISTOP    2
`define FPBS_C_INC      3
`define FPBS_C_DEC      4
`define FPBS_C_CCLR     5
`define FPBS_C_CLEN     6
`define FPBS_C_CPCS     7
`define FPBS_C_CONF     8
`define FPBS_C_PART     9
// ==========================================
// widths
`define FPBS_QTY_W      20
`define FPBS_PART_W     7
// ==========================================
// status and rate register fields
`define FPBS_ST_PINS_W  5
`define FPBS_ST_STATE   5
`define FPBS_ST_INT     8
`define FPBS_ST_PERMIT  9
`define FPBS_ST_FLASH   10
`define FPBS_RT_W       16
`define FPBS_USE_LSB    24
`define FPBS_USE_W      8
// ==========================================
// timing
`define FPBS_CLK_NS     4
`define FPBS_CLK_KHZ    250000
`define FPBS_TICK_NS    1000
`define FPBS_TICK_CYC   (`FPBS_TICK_NS / `FPBS_CLK_NS)
`define FPBS_FLASH_MS   250
`define FPBS_FLASH_CYC  (`FPBS_FLASH_MS * `FPBS_CLK_KHZ)
`define FPBS_US_PER_MIN 32'h0393_8700
`define FPBS_PERCENT    32'h0000_0064
`endif
